// *** logic/pllcd_clock_config.sv ***
// clock-tree configuration registers, ratio decode and glitch-free dividers
//
// How it works
// - multiplier is nine bits, high bit on top
// - multiplier code zero reserved, else equals code
// - multiplier low byte resets to eight
// - N ratio bits 7:5, zero means eight
// - PDM ratio bits 4:2, power of two
// - M ratio bits 7:2, zero means 64
// - ADC modulator ratio codes 0..2 give 1,2,4
// - DAC modulator ratio codes 0..2 give 1,2,4
// - bit 2 is primary bit-clock divider top
// - bit 1 is secondary bit-clock divider top
// - bit-clock code zero divides by 512
// - auto detection overrides all programmed ratios
// - multiplier top bit from lower register input
// - each divider runs only when enabled
`timescale 1ns/1ps

module pllcd_clock_config (
  // clock and reset
  input  wire logic                       clock,
  input  wire logic                       rst,
  // control port
  input  wire logic                       regWrite,
  input  wire logic                       regRead,
  input  wire logic [7:0]                 regAddr,
  input  wire logic [7:0]                 regWriteData,
  output logic      [7:0]                 regReadData,
  output logic                            regReadValid,
  // neighbouring configuration
  input  wire logic                       pll_int_mult_high_bit,
  input  wire logic [7:0]                 secondary_bitclk_div_low,
  input  wire pllcd_pkg::pllcd_enable_type dividerEnable,
  input  wire logic                       autoDetectEnable,
  input  wire pllcd_pkg::pllcd_ratio_type autoRatio,
  // results
  output pllcd_pkg::pllcd_ratio_type      activeRatio,
  output pllcd_pkg::pllcd_clkout_type     dividedClock
);

  localparam int NUM_DIV = 7;

  logic [7:0] pll_int_mult_low;
  logic [7:0] n_and_pdm_divider;
  logic [7:0] m_and_adc_mod_divider;
  logic [7:0] dac_mod_and_bitclk_high;
  logic [7:0] primary_bitclk_div_low;

  pllcd_pkg::pllcd_ratio_type  programmedRatio;
  pllcd_pkg::pllcd_ratio_type  next_activeRatio;

  // register writes; reserved bits store what software gives, it must write zero
  always_ff @(posedge clock) begin
    if (rst) begin
      pll_int_mult_low        <= pllcd_pkg::RST_PLL_INT_MULT_LOW;
      n_and_pdm_divider       <= pllcd_pkg::RST_N_AND_PDM_DIVIDER;
      m_and_adc_mod_divider   <= pllcd_pkg::RST_M_AND_ADC_MOD_DIVIDER;
      dac_mod_and_bitclk_high <= pllcd_pkg::RST_DAC_MOD_AND_BITCLK_HI;
      primary_bitclk_div_low  <= pllcd_pkg::RST_PRIMARY_BITCLK_LOW;
    end else if (regWrite) begin
      if (regAddr == pllcd_pkg::ADDR_PLL_INT_MULT_LOW) begin
        pll_int_mult_low <= regWriteData;
      end else if (regAddr == pllcd_pkg::ADDR_N_AND_PDM_DIVIDER) begin
        n_and_pdm_divider <= regWriteData;
      end else if (regAddr == pllcd_pkg::ADDR_M_AND_ADC_MOD_DIVIDER) begin
        m_and_adc_mod_divider <= regWriteData;
      end else if (regAddr == pllcd_pkg::ADDR_DAC_MOD_AND_BITCLK_HI) begin
        // read-only bit 0 never stored
        dac_mod_and_bitclk_high <= {regWriteData[7:1], 1'b0};
      end else if (regAddr == pllcd_pkg::ADDR_PRIMARY_BITCLK_LOW) begin
        primary_bitclk_div_low <= regWriteData;
      end
    end
  end

  // read port: one cycle after the strobe; unmapped offsets read zero
  always_ff @(posedge clock) begin
    if (rst) begin
      regReadData  <= 8'h00;
      regReadValid <= 1'b0;
    end else begin
      regReadValid <= regRead;
      if (!regRead) begin
        regReadData <= 8'h00;
      end else if (regAddr == pllcd_pkg::ADDR_PLL_INT_MULT_LOW) begin
        regReadData <= pll_int_mult_low;
      end else if (regAddr == pllcd_pkg::ADDR_N_AND_PDM_DIVIDER) begin
        regReadData <= n_and_pdm_divider;
      end else if (regAddr == pllcd_pkg::ADDR_M_AND_ADC_MOD_DIVIDER) begin
        regReadData <= m_and_adc_mod_divider;
      end else if (regAddr == pllcd_pkg::ADDR_DAC_MOD_AND_BITCLK_HI) begin
        regReadData <= {dac_mod_and_bitclk_high[7:1], 1'b0};
      end else if (regAddr == pllcd_pkg::ADDR_PRIMARY_BITCLK_LOW) begin
        regReadData <= primary_bitclk_div_low;
      end else begin
        regReadData <= 8'h00;
      end
    end
  end

  // code-to-ratio decode
  always_comb begin
    logic [2:0] nCode;
    logic [2:0] pdmCode;
    logic [5:0] mCode;
    logic [1:0] adcCode;
    logic [1:0] dacCode;
    logic [8:0] priCode;
    logic [8:0] secCode;
    nCode   = n_and_pdm_divider[pllcd_pkg::N_DIV_MSB:pllcd_pkg::N_DIV_LSB];
    pdmCode = n_and_pdm_divider[pllcd_pkg::PDM_DIVIDER_RATIO_MSB:pllcd_pkg::PDM_DIVIDER_RATIO_LSB];
    mCode   = m_and_adc_mod_divider[pllcd_pkg::M_DIV_MSB:pllcd_pkg::M_DIV_LSB];
    adcCode = m_and_adc_mod_divider[pllcd_pkg::ADC_MOD_MSB:pllcd_pkg::ADC_MOD_LSB];
    dacCode = dac_mod_and_bitclk_high[pllcd_pkg::DAC_MOD_MSB:pllcd_pkg::DAC_MOD_LSB];
    priCode = {dac_mod_and_bitclk_high[pllcd_pkg::PRI_BCLK_HI], primary_bitclk_div_low};
    secCode = {dac_mod_and_bitclk_high[pllcd_pkg::SEC_BCLK_HI], secondary_bitclk_div_low};
    // high bit comes from the lower register, low byte from here
    programmedRatio.pllMult = {pll_int_mult_high_bit, pll_int_mult_low};
    programmedRatio.nRatio = (nCode == 3'h0) ? pllcd_pkg::N_DIV_ZERO_RATIO : {1'b0, nCode};
    // reserved codes clamp to the top legal ratio rather than wrap
    if (pdmCode > pllcd_pkg::PDM_CODE_MAX) begin
      programmedRatio.pdmRatio = 5'h10;
    end else begin
      programmedRatio.pdmRatio = 5'(5'h01 << pdmCode);
    end
    programmedRatio.mRatio = (mCode == 6'h00) ? pllcd_pkg::M_DIV_ZERO_RATIO : {1'b0, mCode};
    programmedRatio.adcModRatio = (adcCode == pllcd_pkg::MOD_CODE_RESERVED) ? 3'h4
                                : 3'(3'h1 << adcCode);
    programmedRatio.dacModRatio = (dacCode == pllcd_pkg::MOD_CODE_RESERVED) ? 3'h4
                                : 3'(3'h1 << dacCode);
    programmedRatio.primaryBclkRatio   = (priCode == 9'h000) ? pllcd_pkg::BCLK_ZERO_RATIO
                                       : {1'b0, priCode};
    programmedRatio.secondaryBclkRatio = (secCode == 9'h000) ? pllcd_pkg::BCLK_ZERO_RATIO
                                       : {1'b0, secCode};
  end

  // auto detection wins over every programmed field
  always_comb begin
    next_activeRatio = autoDetectEnable ? autoRatio : programmedRatio;
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      activeRatio <= '0;
    end else begin
      activeRatio <= next_activeRatio;
    end
  end

  // per-divider ratio vector, widest is 512
  logic [9:0] divRatio [NUM_DIV];
  logic [NUM_DIV-1:0] divEnable;
  logic [NUM_DIV-1:0] divOut;

  always_comb begin
    divRatio[0] = {6'h00, activeRatio.nRatio};
    divRatio[1] = {3'h0, activeRatio.mRatio};
    divRatio[2] = {5'h00, activeRatio.pdmRatio};
    divRatio[3] = {7'h00, activeRatio.adcModRatio};
    divRatio[4] = {7'h00, activeRatio.dacModRatio};
    divRatio[5] = activeRatio.primaryBclkRatio;
    divRatio[6] = activeRatio.secondaryBclkRatio;
    divEnable   = {dividerEnable.secondaryBclkEn, dividerEnable.primaryBclkEn, dividerEnable.dacModEn,
                   dividerEnable.adcModEn, dividerEnable.pdmEn, dividerEnable.mEn, dividerEnable.nEn};
  end

  // dividers: ratio latched only while disabled or at the end of a period, so no runt pulse
  genvar gi;
  generate
    for (gi = 0; gi < NUM_DIV; gi++) begin : gen_div
      logic [9:0] count;
      logic [9:0] heldRatio;
      logic       clkBit;
      always_ff @(posedge clock) begin
        if (rst || !divEnable[gi]) begin
          count     <= 10'h000;
          heldRatio <= divRatio[gi];
          clkBit    <= 1'b0;
        end else if (count >= heldRatio - 10'h001) begin
          count     <= 10'h000;
          heldRatio <= divRatio[gi];
          clkBit    <= (divRatio[gi] != 10'h001);
        end else begin
          count  <= count + 10'h001;
          // high for the first half of the period, odd ratios low one longer
          clkBit <= ((count + 10'h001) < (heldRatio >> 1));
        end
      end
      assign divOut[gi] = (heldRatio == 10'h001) ? divEnable[gi] : clkBit;
    end
  endgenerate

  // ratio one passes the enable, still no gated glitch since it is registered
  always_ff @(posedge clock) begin
    if (rst) begin
      dividedClock <= '0;
    end else begin
      dividedClock <= {divOut[0], divOut[1], divOut[2], divOut[3], divOut[4], divOut[5], divOut[6]};
    end
  end

endmodule

// *** include/pllcd_pkg.sv ***
// package: register map, field layout, reset values and carriers of the clock-tree config block
package pllcd_pkg;

  // register offsets on the control port
  localparam logic [7:0] ADDR_PLL_INT_MULT_LOW      = 8'h38;
  localparam logic [7:0] ADDR_N_AND_PDM_DIVIDER     = 8'h39;
  localparam logic [7:0] ADDR_M_AND_ADC_MOD_DIVIDER = 8'h3A;
  localparam logic [7:0] ADDR_DAC_MOD_AND_BITCLK_HI = 8'h3B;
  localparam logic [7:0] ADDR_PRIMARY_BITCLK_LOW    = 8'h3C;

  // reset values
  localparam logic [7:0] RST_PLL_INT_MULT_LOW      = 8'h08;
  localparam logic [7:0] RST_N_AND_PDM_DIVIDER     = 8'h20;
  localparam logic [7:0] RST_M_AND_ADC_MOD_DIVIDER = 8'h04;
  localparam logic [7:0] RST_DAC_MOD_AND_BITCLK_HI = 8'h00;
  localparam logic [7:0] RST_PRIMARY_BITCLK_LOW    = 8'h01;

  // field positions
  localparam int N_DIV_LSB      = 5;
  localparam int N_DIV_MSB      = 7;
  localparam int PDM_DIVIDER_RATIO_LSB    = 2;
  localparam int PDM_DIVIDER_RATIO_MSB    = 4;
  localparam int M_DIV_LSB      = 2;
  localparam int M_DIV_MSB      = 7;
  localparam int ADC_MOD_LSB    = 0;
  localparam int ADC_MOD_MSB    = 1;
  localparam int DAC_MOD_LSB    = 4;
  localparam int DAC_MOD_MSB    = 5;
  localparam int PRI_BCLK_HI    = 2;
  localparam int SEC_BCLK_HI    = 1;
  localparam int CFG21_RO_BIT   = 0;

  // decode constants for code zero and for the top legal and reserved codes
  localparam logic [3:0] N_DIV_ZERO_RATIO  = 4'h8;
  localparam logic [6:0] M_DIV_ZERO_RATIO  = 7'h40;
  localparam logic [9:0] BCLK_ZERO_RATIO   = 10'h200;
  localparam logic [2:0] PDM_CODE_MAX      = 3'h4;
  localparam logic [1:0] MOD_CODE_RESERVED = 2'h3;

  // decoded ratios, one carrier
  typedef struct packed {
    logic [8:0] pllMult;
    logic [3:0] nRatio;
    logic [4:0] pdmRatio;
    logic [6:0] mRatio;
    logic [2:0] adcModRatio;
    logic [2:0] dacModRatio;
    logic [9:0] primaryBclkRatio;
    logic [9:0] secondaryBclkRatio;
  } pllcd_ratio_type;

  // divider enables
  typedef struct packed {
    logic nEn;
    logic mEn;
    logic pdmEn;
    logic adcModEn;
    logic dacModEn;
    logic primaryBclkEn;
    logic secondaryBclkEn;
  } pllcd_enable_type;

  // divided clock outputs
  typedef struct packed {
    logic nClk;
    logic mClk;
    logic pdmClk;
    logic adcModClk;
    logic dacModClk;
    logic primaryBclk;
    logic secondaryBclk;
  } pllcd_clkout_type;

endpackage

// *** tb/pllcd_clock_config_sva.sv ***
// checker: port-level assertions for the clock-tree config block
`timescale 1ns/1ps
module pllcd_clock_config_sva (
  // clock and reset
  input wire logic                        clock,
  input wire logic                        rst,
  // control port
  input wire logic                        regRead,
  input wire logic [7:0]                  regAddr,
  input wire logic [7:0]                  regReadData,
  input wire logic                        regReadValid,
  // neighbouring configuration
  input wire logic                        pll_int_mult_high_bit,
  input wire logic [7:0]                  secondary_bitclk_div_low,
  input wire pllcd_pkg::pllcd_enable_type dividerEnable,
  input wire logic                        autoDetectEnable,
  input wire pllcd_pkg::pllcd_ratio_type  autoRatio,
  // results
  input wire pllcd_pkg::pllcd_ratio_type  activeRatio,
  input wire pllcd_pkg::pllcd_clkout_type dividedClock
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // previous edge was out of reset, split by source of ratios
  logic decoded;
  logic fromAuto;
  always_ff @(posedge clock) begin
    decoded  <= !rst && !autoDetectEnable;
    fromAuto <= !rst && autoDetectEnable;
  end
  property p_readZero; regRead && regAddr == 8'h3B |=> regReadValid && !regReadData[0]; endproperty
  a_readZero: assert property (p_readZero) else $error("read-only bit read as one");
  property p_multHigh; decoded |-> activeRatio.pllMult[8] == $past(pll_int_mult_high_bit); endproperty
  a_multHigh: assert property (p_multHigh) else $error("multiplier top bit wrong");
  property p_secLow;
    decoded && $past(secondary_bitclk_div_low) != 8'h00
      |-> activeRatio.secondaryBclkRatio[7:0] == $past(secondary_bitclk_div_low);
  endproperty
  a_secLow: assert property (p_secLow) else $error("secondary ratio low byte wrong");
  property p_auto; fromAuto |-> activeRatio == $past(autoRatio); endproperty
  a_auto: assert property (p_auto) else $error("auto ratios not applied");
  property p_nRange; decoded |-> activeRatio.nRatio inside {[4'h1:4'h8]}; endproperty
  a_nRange: assert property (p_nRange) else $error("N ratio out of range");
  property p_pdm; decoded |-> $onehot(activeRatio.pdmRatio); endproperty
  a_pdm: assert property (p_pdm) else $error("PDM ratio not a power of two");
  property p_adc; decoded |-> activeRatio.adcModRatio inside {3'h1, 3'h2, 3'h4}; endproperty
  a_adc: assert property (p_adc) else $error("ADC modulator ratio illegal");
  // enable passes one flop into the divider and one into the output register
  property p_nOff; !dividerEnable.nEn [*3] |-> !dividedClock.nClk; endproperty
  a_nOff: assert property (p_nOff) else $error("N clock runs while disabled");
  c_auto: cover property (fromAuto);
  c_read: cover property (regReadValid);
  c_nClk: cover property ($rose(dividedClock.nClk));
endmodule
bind pllcd_clock_config pllcd_clock_config_sva i_sva (.clock, .rst, .regRead, .regAddr, .regReadData,
  .regReadValid, .pll_int_mult_high_bit, .secondary_bitclk_div_low, .dividerEnable, .autoDetectEnable,
  .autoRatio, .activeRatio, .dividedClock);

// *** tb/pllcd_clock_config_test.sv ***
// testbench: register access, ratio decode, auto override and dividers
`timescale 1ns/1ps
module pllcd_clock_config_test;
  logic                        clock = 1'b0;
  logic                        rst = 1'b1;
  logic                        regWrite = 1'b0;
  logic                        regRead = 1'b0;
  logic [7:0]                  regAddr = 8'h00;
  logic [7:0]                  regWriteData = 8'h00;
  logic [7:0]                  regReadData;
  logic                        regReadValid;
  logic                        pll_int_mult_high_bit = 1'b0;
  logic [7:0]                  secondary_bitclk_div_low = 8'h00;
  pllcd_pkg::pllcd_enable_type dividerEnable = '0;
  logic                        autoDetectEnable = 1'b0;
  pllcd_pkg::pllcd_ratio_type  autoRatio = '0;
  pllcd_pkg::pllcd_ratio_type  activeRatio;
  pllcd_pkg::pllcd_clkout_type dividedClock;
  logic [15:0]                 wave;
  logic [7:0]                  resetVal [5] = '{8'h08, 8'h20, 8'h04, 8'h00, 8'h01};
  int                          mismatches = 0;
  int                          comparisons = 0;

  always #12.5 clock = ~clock;

  pllcd_clock_config i_dut (.clock, .rst, .regWrite, .regRead, .regAddr, .regWriteData, .regReadData,
    .regReadValid, .pll_int_mult_high_bit, .secondary_bitclk_div_low, .dividerEnable, .autoDetectEnable,
    .autoRatio, .activeRatio, .dividedClock);

  task automatic check(input logic [50:0] got, input logic [50:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  // returns once the decoded ratios reflect the write
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    regWrite <= 1'b1;
    regAddr <= a;
    regWriteData <= d;
    @(posedge clock);
    regWrite <= 1'b0;
    repeat (2) @(negedge clock);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clock);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge clock);
    regRead <= 1'b0;
    @(negedge clock);
    check({regReadValid, regReadData}, {1'b1, exp});
  endtask

  // phase of the divided clock is free, so only its shape is judged
  task automatic grab;
    repeat (16) begin
      @(negedge clock);
      wave = {wave[14:0], dividedClock.nClk};
    end
  endtask

  task automatic summarize;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    repeat (12) @(posedge clock);
    rst <= 1'b0;
    for (int i = 0; i < 5; i++) begin
      rd(8'h38 + 8'(i), resetVal[i]);
    end
    rd(8'h37, 8'h00);
    check(activeRatio, {9'h008, 4'h1, 5'h01, 7'h01, 3'h1, 3'h1, 10'h001, 10'h200});
    for (int i = 0; i < 8; i++) begin
      wr(8'h39, {i[2:0], 3'(i % 5), 2'b00});
      check(activeRatio.nRatio, (i == 0) ? 8 : i);
      check(activeRatio.pdmRatio, 1 << (i % 5));
    end
    for (int i = 0; i < 4; i++) begin
      wr(8'h3A, {6'(i * 21), 2'(i % 3)});
      check(activeRatio.mRatio, (i == 0) ? 64 : i * 21);
      check(activeRatio.adcModRatio, 1 << (i % 3));
    end
    @(posedge clock);
    secondary_bitclk_div_low <= 8'h05;
    // bit 0 set on purpose: it must not stick
    wr(8'h3B, 8'h27);
    rd(8'h3B, 8'h26);
    check(activeRatio.dacModRatio, 4);
    check(activeRatio.primaryBclkRatio, 257);
    check(activeRatio.secondaryBclkRatio, 261);
    wr(8'h3B, 8'h14);
    wr(8'h3C, 8'hFF);
    check(activeRatio.dacModRatio, 2);
    check(activeRatio.primaryBclkRatio, 511);
    wr(8'h3B, 8'h00);
    wr(8'h3C, 8'h00);
    check(activeRatio.primaryBclkRatio, 512);
    check(activeRatio.secondaryBclkRatio, 5);
    @(posedge clock);
    pll_int_mult_high_bit <= 1'b1;
    wr(8'h38, 8'hFF);
    check(activeRatio.pllMult, 511);
    wr(8'h38, 8'h01);
    check(activeRatio.pllMult, 257);
    wr(8'h3D, 8'hAA);
    rd(8'h3D, 8'h00);
    rd(8'h38, 8'h01);
    @(posedge clock);
    autoRatio <= {9'h1AB, 4'h3, 5'h02, 7'h11, 3'h2, 3'h4, 10'h123, 10'h2F0};
    autoDetectEnable <= 1'b1;
    repeat (3) @(negedge clock);
    check(activeRatio, autoRatio);
    @(posedge clock);
    autoDetectEnable <= 1'b0;
    wr(8'h39, 8'h80);
    @(posedge clock);
    dividerEnable <= '1;
    repeat (4) @(negedge clock);
    grab();
    check(wave ^ {wave[1:0], wave[15:2]}, 16'hFFFF);
    wr(8'h39, 8'h40);
    repeat (4) @(negedge clock);
    grab();
    check(wave ^ {wave[0], wave[15:1]}, 16'hFFFF);
    @(posedge clock);
    dividerEnable <= '0;
    repeat (3) @(negedge clock);
    check(dividedClock, 7'h00);
    summarize();
  end

  initial begin
    repeat (5000) @(posedge clock);
    mismatches++;
    summarize();
  end
endmodule
